// ==== common/sslr_pkg.sv ====
// sslr_pkg: offsets, field positions, reset codes and timing constants
// for the supply status and level register bank.
// assumes byte addresses on APB and a 40 MHz core_clk.
package sslr_pkg;
   // register byte offsets
   localparam logic [7:0]  STATUS_OFS = 8'h30;
   localparam logic [7:0]  CORE_OFS   = 8'h34;
   localparam logic [7:0]  PLL_OFS    = 8'h40;
   localparam logic [7:0]  STEP_OFS   = 8'h44;
   // supply status bit positions
   localparam int          OSC_BIT         = 24;
   localparam int          PLL_GOOD_BIT    = 19;
   localparam int          CORE_GOOD_BIT   = 16;
   localparam int          ANALOG_ILIM_BIT = 9;
   localparam int          CORE_ILIM_BIT   = 8;
   localparam int          ANALOG_SS_BIT   = 1;
   localparam int          CORE_SS_BIT     = 0;
   // implemented bits of each register
   localparam logic [31:0] STATUS_MASK = 32'h0109_0303;
   localparam logic [31:0] CORE_MASK   = 32'h0000_007F;
   localparam logic [31:0] PLL_MASK    = 32'h0000_0007;
   localparam logic [31:0] STEP_MASK   = 32'h0000_0003;
   // level codes
   localparam int          CORE_W     = 7;
   localparam int          PLL_W      = 3;
   localparam int          STEP_W     = 2;
   localparam logic [6:0]  CORE_MAX   = 7'h46;
   localparam logic [6:0]  CORE_RESET = 7'h00;
   localparam logic [2:0]  PLL_MAX    = 3'h7;
   localparam logic [2:0]  PLL_RESET  = 3'h0;
   // step warning flag positions
   localparam int          CORE_STEP_BIT = 0;
   localparam int          PLL_STEP_BIT  = 1;
   // one core step of 10 mV per microsecond
   localparam int          STEP_TIME_NS  = 1000;
   localparam int          CLK_PERIOD_NS = 25;
   localparam int          STEP_CYCLES   = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic {BOOT_LOAD, BOOT_RUN} sslr_boot_type;
endpackage

// ==== core/sslr_status_sampler.sv ====
// sslr_status_sampler: registers the live supply health levels into the
// status word layout, reserved bits held at zero.
// assumes all health inputs are synchronous to core_clk.
`timescale 1ns/1ps
module sslr_status_sampler
   import sslr_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        resetn,
   // live health levels
   input  wire logic        oscStable,
   input  wire logic        pllSupplyGood,
   input  wire logic        coreSupplyGood,
   input  wire logic        analogConverterLimit,
   input  wire logic        coreConverterLimit,
   input  wire logic        analogConverterSoftStart,
   input  wire logic        coreConverterSoftStart,
   // sampled word
   output      logic [31:0] statusWord
);
   logic [31:0] next_statusWord;

   always_comb begin
      next_statusWord                  = 32'h0000_0000;
      next_statusWord[OSC_BIT]         = oscStable;
      next_statusWord[PLL_GOOD_BIT]    = pllSupplyGood;
      next_statusWord[CORE_GOOD_BIT]   = coreSupplyGood;
      next_statusWord[ANALOG_ILIM_BIT] = analogConverterLimit;
      next_statusWord[CORE_ILIM_BIT]   = coreConverterLimit;
      next_statusWord[ANALOG_SS_BIT]   = analogConverterSoftStart;
      next_statusWord[CORE_SS_BIT]     = coreConverterSoftStart;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) statusWord <= 32'h0000_0000;
      else         statusWord <= next_statusWord;
   end
endmodule // sslr_status_sampler

// ==== core/sslr_level_reg.sv ====
// sslr_level_reg: one level code register, loaded from its strap once
// after reset and then written by software, clamped to a top code.
// assumes loadStrap and writeEn are never high together.
`timescale 1ns/1ps
module sslr_level_reg
   import sslr_pkg::*;
#(
   parameter int               WIDTH     = 7,
   parameter logic [WIDTH-1:0] MAXCODE   = '1,
   parameter logic [WIDTH-1:0] RESETCODE = '0
)(
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             resetn,
   // strap load and software write
   input  wire logic             loadStrap,
   input  wire logic [WIDTH-1:0] strapCode,
   input  wire logic             writeEn,
   input  wire logic [WIDTH-1:0] writeCode,
   // held code
   output      logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] next_level;

   function automatic logic [WIDTH-1:0] limitCode(input logic [WIDTH-1:0] code);
      return (code > MAXCODE) ? MAXCODE : code;
   endfunction

   assign next_level = loadStrap ? limitCode(strapCode) :
                       writeEn   ? limitCode(writeCode) : level;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) level <= RESETCODE;
      else         level <= next_level;
   end
endmodule // sslr_level_reg

// ==== core/sslr_supply_status_level_regs.sv ====
// sslr_supply_status_level_regs: APB register bank reporting supply
// health and holding the core and pll regulator level codes.
// assumes an APB master on core_clk and straps stable at reset release.
//
// The APB register port was decided locally.
`timescale 1ns/1ps

module sslr_supply_status_level_regs
   import sslr_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              resetn,
   // apb slave
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output      logic [31:0]       prdata,
   output      logic              pready,
   output      logic              pslverr,
   // live supply health
   input  wire logic              oscStable,
   input  wire logic              pllSupplyGood,
   input  wire logic              coreSupplyGood,
   input  wire logic              analogConverterLimit,
   input  wire logic              coreConverterLimit,
   input  wire logic              analogConverterSoftStart,
   input  wire logic              coreConverterSoftStart,
   // boot straps
   input  wire logic [CORE_W-1:0] coreLevelStrap,
   input  wire logic [PLL_W-1:0]  pllLevelStrap,
   // level codes to the regulators
   output      logic [CORE_W-1:0] coreLevel,
   output      logic [PLL_W-1:0]  pllLevel
);
   localparam int GAP_W = $clog2(STEP_CYCLES + 1);
   localparam logic [GAP_W-1:0] GAP_FULL = GAP_W'(STEP_CYCLES);

   // address decode helpers
   function automatic logic addrIs(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
      return addr == ADDR_W'(ofs);
   endfunction

   function automatic logic [CORE_W-1:0] codeDistance(input logic [CORE_W-1:0] a,
                                                      input logic [CORE_W-1:0] b);
      return (a > b) ? a - b : b - a;
   endfunction

   // bus phases
   logic                setupPhase;
   logic                accessDone;
   logic                writeFire;
   // decode
   logic                hitStatus;
   logic                hitCore;
   logic                hitPll;
   logic                hitStep;
   logic                anyHit;
   logic [31:0]         readWord;
   // next values of the bus outputs
   logic [31:0]         next_prdata;
   logic                next_pready;
   logic                next_pslverr;
   // register strobes
   logic                coreWrite;
   logic                pllWrite;
   logic                stepClear;
   // boot strap load
   sslr_boot_type       bootState;
   sslr_boot_type       next_bootState;
   logic                loadStrap;
   // status word
   logic [31:0]         statusWord;
   // step monitor
   logic [GAP_W-1:0]    coreGap;
   logic [GAP_W-1:0]    next_coreGap;
   logic                coreChanges;
   logic                coreStepBad;
   logic                pllStepBad;
   logic [STEP_W-1:0]   stepFlags;
   logic [STEP_W-1:0]   next_stepFlags;
   logic [STEP_W-1:0]   stepSet;
   logic [STEP_W-1:0]   stepClr;

   // bus phases: zero wait states, pready comes up in the access cycle
   assign setupPhase = psel & ~penable;
   assign accessDone = psel & penable & pready;
   assign writeFire  = accessDone & pwrite;

   // decode
   assign hitStatus = addrIs(paddr, STATUS_OFS);
   assign hitCore   = addrIs(paddr, CORE_OFS);
   assign hitPll    = addrIs(paddr, PLL_OFS);
   assign hitStep   = addrIs(paddr, STEP_OFS);
   assign anyHit    = hitStatus | hitCore | hitPll | hitStep;

   // read mux, unused bits forced to zero
   assign readWord = hitStatus ? (statusWord & STATUS_MASK) :
                     hitCore   ? {{(32-CORE_W){1'b0}}, coreLevel} :
                     hitPll    ? {{(32-PLL_W){1'b0}}, pllLevel} :
                     hitStep   ? {{(32-STEP_W){1'b0}}, stepFlags} :
                                 32'h0000_0000;

   assign next_prdata  = (setupPhase & ~pwrite) ? readWord : prdata;
   assign next_pready  = setupPhase;
   assign next_pslverr = setupPhase & ~anyHit;

   // only the level and step registers take writes; status ignores them
   assign coreWrite = writeFire & hitCore;
   assign pllWrite  = writeFire & hitPll;
   assign stepClear = writeFire & hitStep;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // strap load on the first edge after reset release
   always_comb begin
      case (bootState)
         BOOT_LOAD: next_bootState = BOOT_RUN;
         BOOT_RUN:  next_bootState = BOOT_RUN;
         default:   next_bootState = BOOT_LOAD;
      endcase
   end

   assign loadStrap = (bootState == BOOT_LOAD);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) bootState <= BOOT_LOAD;
      else         bootState <= next_bootState;
   end

   // live health, sampled every cycle so each read sees the present state
   sslr_status_sampler u_status (
      .core_clk                 (core_clk),
      .resetn                   (resetn),
      .oscStable                (oscStable),
      .pllSupplyGood            (pllSupplyGood),
      .coreSupplyGood           (coreSupplyGood),
      .analogConverterLimit     (analogConverterLimit),
      .coreConverterLimit       (coreConverterLimit),
      .analogConverterSoftStart (analogConverterSoftStart),
      .coreConverterSoftStart   (coreConverterSoftStart),
      .statusWord               (statusWord)
   );

   // core level, codes above 70 are clamped to 70
   sslr_level_reg #(
      .WIDTH     (CORE_W),
      .MAXCODE   (CORE_MAX),
      .RESETCODE (CORE_RESET)
   ) u_core_level (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .loadStrap (loadStrap),
      .strapCode (coreLevelStrap),
      .writeEn   (coreWrite),
      .writeCode (pwdata[CORE_W-1:0]),
      .level     (coreLevel)
   );

   // pll regulator level, all eight codes are legal
   sslr_level_reg #(
      .WIDTH     (PLL_W),
      .MAXCODE   (PLL_MAX),
      .RESETCODE (PLL_RESET)
   ) u_pll_level (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .loadStrap (loadStrap),
      .strapCode (pllLevelStrap),
      .writeEn   (pllWrite),
      .writeCode (pwdata[PLL_W-1:0]),
      .level     (pllLevel)
   );

   // step monitor: the regulators only settle cleanly when software
   // ramps slowly, so fast core moves and pll rises of more than one code are recorded for software to see
   assign coreChanges = coreWrite & (pwdata[CORE_W-1:0] != coreLevel);
   assign coreStepBad = coreChanges &
                        ((codeDistance(pwdata[CORE_W-1:0], coreLevel) > 7'h01) |
                         (coreGap < GAP_FULL));
   assign pllStepBad  = pllWrite &
                        ({1'b0, pwdata[PLL_W-1:0]} > ({1'b0, pllLevel} + 4'h1));

   assign next_coreGap = coreChanges ? {GAP_W{1'b0}} :
                         (coreGap == GAP_FULL) ? coreGap : coreGap + 1'b1;

   // write one clears; a new event in the same cycle wins
   assign stepSet = {pllStepBad, coreStepBad};
   assign stepClr = stepClear ? pwdata[STEP_W-1:0] : {STEP_W{1'b0}};
   assign next_stepFlags = (stepFlags & ~stepClr) | stepSet;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         coreGap   <= GAP_FULL;
         stepFlags <= {STEP_W{1'b0}};
      end else begin
         coreGap   <= next_coreGap;
         stepFlags <= next_stepFlags;
      end
   end

   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   sequence s_statusRead;
      setupPhase && hitStatus && !pwrite;
   endsequence

   sequence s_coreWrite;
      setupPhase && hitCore && pwrite ##1 accessDone;
   endsequence

   sequence s_pllWrite;
      setupPhase && hitPll && pwrite ##1 accessDone;
   endsequence

   property p_oscBit;
      s_statusRead |=> prdata[OSC_BIT] == $past(oscStable, 2);
   endproperty
   a_oscBit: assert property (p_oscBit)
      else $error("oscillator stable bit does not follow its input");

   property p_pllGoodBit;
      s_statusRead |=> pready && (prdata[PLL_GOOD_BIT] == $past(pllSupplyGood, 2));
   endproperty
   a_pllGoodBit: assert property (p_pllGoodBit)
      else $error("pll supply good bit does not follow its input");

   property p_coreGoodBit;
      s_statusRead |=> prdata[CORE_GOOD_BIT] == $past(coreSupplyGood, 2);
   endproperty
   a_coreGoodBit: assert property (p_coreGoodBit)
      else $error("core supply good bit does not follow its input");

   property p_limitBits;
      s_statusRead |=> prdata[ANALOG_ILIM_BIT] == $past(analogConverterLimit, 2)
                    && prdata[CORE_ILIM_BIT] == $past(coreConverterLimit, 2);
   endproperty
   a_limitBits: assert property (p_limitBits)
      else $error("current limit bits do not follow their inputs");

   property p_softStartBits;
      s_statusRead |=> prdata[ANALOG_SS_BIT] == $past(analogConverterSoftStart, 2)
                    && prdata[CORE_SS_BIT] == $past(coreConverterSoftStart, 2);
   endproperty
   a_softStartBits: assert property (p_softStartBits)
      else $error("soft-start bits do not follow their inputs");

   property p_statusWriteIgnored;
      setupPhase && hitStatus && pwrite
         |=> accessDone && !pslverr
             ##1 $stable(coreLevel) && $stable(pllLevel) && $stable(stepFlags);
   endproperty
   a_statusWriteIgnored: assert property (p_statusWriteIgnored)
      else $error("write to the status word changed state");

   property p_coreWrite;
      s_coreWrite |=> coreLevel == (($past(pwdata[CORE_W-1:0]) > CORE_MAX) ?
                                    CORE_MAX : $past(pwdata[CORE_W-1:0]));
   endproperty
   a_coreWrite: assert property (p_coreWrite)
      else $error("core level did not take the written code");

   property p_coreRange;
      coreLevel <= CORE_MAX;
   endproperty
   a_coreRange: assert property (p_coreRange)
      else $error("core level code above 70");

   property p_strapLoad;
      bootState == BOOT_LOAD |=> coreLevel == (($past(coreLevelStrap) > CORE_MAX) ?
                                              CORE_MAX : $past(coreLevelStrap))
                              && pllLevel == $past(pllLevelStrap)
                              && bootState == BOOT_RUN;
   endproperty
   a_strapLoad: assert property (p_strapLoad)
      else $error("level codes not loaded from the straps after reset");

   property p_pllWrite;
      s_pllWrite |=> pllLevel == $past(pwdata[PLL_W-1:0]) ##1 $stable(pllLevel) || pllWrite;
   endproperty
   a_pllWrite: assert property (p_pllWrite)
      else $error("pll level did not take the written code");

   property p_reservedZero;
      setupPhase && !pwrite && (hitCore || hitPll)
         |=> (prdata & ~(CORE_MASK | PLL_MASK)) == 32'h0000_0000;
   endproperty
   a_reservedZero: assert property (p_reservedZero)
      else $error("reserved level bits read as non-zero");

   property p_stepSetWins;
      coreStepBad |=> stepFlags[CORE_STEP_BIT];
   endproperty
   a_stepSetWins: assert property (p_stepSetWins)
      else $error("core step warning lost");

   property p_unmappedError;
      setupPhase && !anyHit |=> pready && pslverr
         ##1 $stable(coreLevel) && $stable(pllLevel) && $stable(stepFlags);
   endproperty
   a_unmappedError: assert property (p_unmappedError)
      else $error("unmapped address not answered with an error");

   // pready is a single-cycle answer, never held into the next cycle
   property p_readyPulse;
      pready |=> !pready;
   endproperty
   a_readyPulse: assert property (p_readyPulse)
      else $error("pready stood longer than one cycle");

   // read data only moves at the setup edge of a read
   property p_readHold;
      !(setupPhase && !pwrite) |=> $stable(prdata);
   endproperty
   a_readHold: assert property (p_readHold)
      else $error("read data changed outside a read setup");

   property p_statusReserved;
      s_statusRead |=> (prdata & ~STATUS_MASK) == 32'h0000_0000;
   endproperty
   a_statusReserved: assert property (p_statusReserved)
      else $error("reserved status bits read as non-zero");

endmodule // sslr_supply_status_level_regs

// ==== sim/tb_supply_status_level_regs.sv ====
// tb_supply_status_level_regs: self-checking bench for the supply status and level bank.
// assumes zero-wait APB answers and straps loaded at the first edge after reset release.
`timescale 1ns/1ps
module tb_supply_status_level_regs;
   import sslr_pkg::*;

   logic              core_clk;
   logic              resetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic              pready;
   logic              pslverr;
   logic [7:0]        paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   // health order: osc, pll good, core good, analog limit, core limit, analog ss, core ss
   logic [6:0]        health;
   logic [CORE_W-1:0] coreLevelStrap;
   logic [CORE_W-1:0] coreLevel;
   logic [PLL_W-1:0]  pllLevelStrap;
   logic [PLL_W-1:0]  pllLevel;
   logic [31:0]       rdData;
   logic              rdErr;
   logic [6:0]        code;
   int                errCount;
   int                totalChecks;
   int                cycleCount;
   int                bitPos [7] = '{OSC_BIT, PLL_GOOD_BIT, CORE_GOOD_BIT, ANALOG_ILIM_BIT,
                                     CORE_ILIM_BIT, ANALOG_SS_BIT, CORE_SS_BIT};
   logic [6:0]        coreCodes [4] = '{7'h00, 7'h46, 7'h47, 7'h45};

   sslr_supply_status_level_regs #(.ADDR_W(8)) sslr_supply_status_level_regs_i (
      .core_clk                 (core_clk),
      .resetn                   (resetn),
      .paddr                    (paddr),
      .psel                     (psel),
      .penable                  (penable),
      .pwrite                   (pwrite),
      .pwdata                   (pwdata),
      .prdata                   (prdata),
      .pready                   (pready),
      .pslverr                  (pslverr),
      .oscStable                (health[0]),
      .pllSupplyGood            (health[1]),
      .coreSupplyGood           (health[2]),
      .analogConverterLimit     (health[3]),
      .coreConverterLimit       (health[4]),
      .analogConverterSoftStart (health[5]),
      .coreConverterSoftStart   (health[6]),
      .coreLevelStrap           (coreLevelStrap),
      .pllLevelStrap            (pllLevelStrap),
      .coreLevel                (coreLevel),
      .pllLevel                 (pllLevel)
   );

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic testDone();
      $display("checks %0d, mismatches %0d", totalChecks, errCount);
      if (errCount == 0 && totalChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // hang guard
   always @(posedge core_clk) begin
      cycleCount = cycleCount + 1;
      if (cycleCount == 20000) begin
         errCount++;
         $display("[FAIL] cycle limit expected below 20000 seen %0d", cycleCount);
         testDone();
      end
   end

   task automatic testEnd(input string what);
      $display("test %s done", what);
   endtask

   task automatic chkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         errCount++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chkFlag(input string what, input logic exp, input logic got);
      totalChecks++;
      if (got !== exp) begin
         errCount++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is sampled high or 20 cycles pass
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdData = prdata;
      rdErr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      chkFlag("pready", 1'b1, pready);
   endtask

   task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      chkWord(what, exp, rdData);
      chkFlag("read pslverr", 1'b0, rdErr);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic expErr);
      xfer(1'b1, a, d);
      chkFlag("write pslverr", expErr, rdErr);
   endtask

   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      health = 7'h00;
      coreLevelStrap = 7'h2A;
      pllLevelStrap = 3'h5;
      errCount = 0;
      totalChecks = 0;
      cycleCount = 0;
      repeat (8) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge core_clk);
      chkWord("core strap", 32'h0000_002A, 32'(coreLevel));
      chkWord("pll strap", 32'h0000_0005, 32'(pllLevel));
      rdChk("core reg", CORE_OFS, 32'h0000_002A);
      rdChk("pll reg", PLL_OFS, 32'h0000_0005);
      rdChk("status idle", STATUS_OFS, 32'h0000_0000);
      testEnd("reset");
      for (int k = 0; k < 7; k++) begin
         health <= 7'(1 << k);
         rdChk("status bit", STATUS_OFS, 32'h1 << bitPos[k]);
      end
      health <= 7'h7F;
      rdChk("status all", STATUS_OFS, 32'h0109_0303);
      wr(STATUS_OFS, 32'hFFFF_FFFF, 1'b0);
      health <= 7'h00;
      rdChk("status live", STATUS_OFS, 32'h0000_0000);
      testEnd("status");
      for (int k = 0; k < 4; k++) begin
         code = (coreCodes[k] > CORE_MAX) ? CORE_MAX : coreCodes[k];
         wr(CORE_OFS, 32'hFFFF_FF80 | 32'(coreCodes[k]), 1'b0);
         rdChk("core reg", CORE_OFS, 32'(code));
         chkWord("core port", 32'(code), 32'(coreLevel));
      end
      for (int c = 0; c < 8; c++) begin
         wr(PLL_OFS, 32'hFFFF_FFF8 | 32'(c), 1'b0);
         rdChk("pll reg", PLL_OFS, 32'(c));
         chkWord("pll port", 32'(c), 32'(pllLevel));
      end
      testEnd("levels");
      xfer(1'b0, 8'h38, 32'h0000_0000);
      chkWord("unmapped data", 32'h0000_0000, rdData);
      chkFlag("unmapped pslverr", 1'b1, rdErr);
      wr(8'h38, 32'h0000_0011, 1'b1);
      rdChk("core kept", CORE_OFS, 32'h0000_0045);
      testEnd("unmapped");
      wr(STEP_OFS, 32'h0000_0003, 1'b0);
      rdChk("step clear", STEP_OFS, 32'h0000_0000);
      wr(PLL_OFS, 32'h0000_0000, 1'b0);
      wr(PLL_OFS, 32'h0000_0001, 1'b0);
      rdChk("pll one step", STEP_OFS, 32'h0000_0000);
      wr(PLL_OFS, 32'h0000_0003, 1'b0);
      rdChk("pll big step", STEP_OFS, 32'h0000_0002);
      wr(STEP_OFS, 32'h0000_0002, 1'b0);
      repeat (STEP_CYCLES + 10) @(posedge core_clk);
      wr(CORE_OFS, 32'h0000_0044, 1'b0);
      rdChk("core slow step", STEP_OFS, 32'h0000_0000);
      wr(CORE_OFS, 32'h0000_0043, 1'b0);
      rdChk("core fast step", STEP_OFS, 32'h0000_0001);
      testEnd("step");
      @(posedge core_clk);
      resetn <= 1'b0;
      coreLevelStrap <= 7'h50;
      pllLevelStrap <= 3'h2;
      repeat (3) @(posedge core_clk);
      chkWord("core in reset", 32'h0000_0000, 32'(coreLevel));
      resetn <= 1'b1;
      repeat (2) @(posedge core_clk);
      chkWord("core restrap", 32'(CORE_MAX), 32'(coreLevel));
      chkWord("pll restrap", 32'h0000_0002, 32'(pllLevel));
      rdChk("core reg restrap", CORE_OFS, 32'h0000_0046);
      testEnd("second reset");
      testDone();
   end
endmodule // tb_supply_status_level_regs
